//--- shared/vol_reset_pkg.sv
// Constants, types and register map of the reset volume ramp block.
// Assumes an eight-bit control port map and one system clock.
package vol_reset_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int VOL_W = 7;

  localparam logic [ADDR_W-1:0] ADDR_VOL_MIX = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_VOL_A = 8'h03;
  localparam logic [ADDR_W-1:0] ADDR_MODE3 = 8'h06;
  localparam logic [ADDR_W-1:0] ADDR_ID = 8'h07;

  localparam int SOFTZERO_LSB = 5;
  localparam int SOFTZERO_MSB = 6;
  localparam int RAMP_UP_BIT = 3;
  localparam int RAMP_DN_BIT = 2;
  localparam int ID_PART_LSB = 4;
  localparam int ID_PART_MSB = 7;
  localparam int ID_REV_MSB = 3;

  localparam logic [VOL_W-1:0] ATTEN_MAX = 7'h7f;
  localparam logic [VOL_W-1:0] VOL_RST = 7'h00;
  localparam logic [DATA_W-1:0] RDATA_NONE = 8'h00;

  typedef enum logic [1:0] {
    SZ_IMMEDIATE = 2'b00,
    SZ_ZERO = 2'b01,
    SZ_SOFT = 2'b10,
    SZ_SOFT_ZERO = 2'b11
  } softzero_t;

  localparam softzero_t SOFTZERO_RST = SZ_SOFT;

  typedef enum logic [1:0] {
    S_HELD = 2'b00,
    S_RAMP_UP = 2'b01,
    S_RUN = 2'b10,
    S_RAMP_DOWN = 2'b11
  } vstate_t;

  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

endpackage

//--- logic/atten_stepper.sv
// Moves the effective attenuation toward a target under the soft/zero mode.
// Assumes tick and zero-crossing strobes come from logic on the same clock.
`timescale 1ns/1ps
module atten_stepper #(
  parameter int W = 7
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [W-1:0] target,
  input wire logic [W-1:0] reset_val,
  input wire vol_reset_pkg::softzero_t mode,
  input wire logic tick,
  input wire logic zero,
  output logic [W-1:0] cur_q
);
  import vol_reset_pkg::*;

  logic jump;
  logic step;
  logic [W-1:0] one;

  assign one = W'(1);

  always_comb begin
    jump = load;
    step = 1'b0;
    case (mode)
      SZ_IMMEDIATE: jump = 1'b1;
      SZ_ZERO: jump = load | zero;
      SZ_SOFT: step = tick;
      SZ_SOFT_ZERO: step = tick & zero;
      default: jump = 1'b1;
    endcase
  end

  // Soft ramps move one 1 dB step per tick (per tick at a zero crossing in mode 11); otherwise the target is taken whole.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_q <= {W{1'b1}};
    end else if (jump) begin
      cur_q <= target; // RQ8
    end else if (step && cur_q < target) begin
      cur_q <= cur_q + one; // RQ9
    end else if (step && cur_q > target) begin
      cur_q <= cur_q - one; // RQ9
    end
  end

  logic unused_rv;
  assign unused_rv = ^reset_val;

endmodule

//--- logic/reset_volume_ramp.sv
// Volume behaviour around chip reset, with the mode registers and part_and_revision_id.
// Assumes a control port drives REG_REQ on CLK; tick and zero strobes share CLK.
// Summary of operation
// [RQ1] Ramp-up select 0: jump from max attenuation to programmed volume on release.
// [RQ2] Ramp-up select 1: ramp up to programmed volume using soft/zero field.
// [RQ3] Release behaviour is identical for pin reset and internal reset.
// [RQ4] Ramp-up select is bit 3, ramp-down select bit 2, of register 06h.
// [RQ5] Ramp-down select 0: jump from programmed volume to max attenuation at reset.
// [RQ6] Ramp-down select 1: ramp to max attenuation before reset takes effect.
// [RQ7] Register 07h is read-only: part code in 7:4, revision in 3:0.
// [RQ8] Field 00 immediate, 01 zero cross, 10 soft ramp default, 11 both.
// [RQ9] Attenuation moves in 1 dB steps from 0 to 127 dB.
// [RQ10] While reset is held the effective volume stays at max attenuation.
`timescale 1ns/1ps
module reset_volume_ramp #(
  parameter logic [3:0] PART_CODE = 4'h5, // Arbitrary value.
  parameter logic [3:0] REVISION = 4'h1
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire vol_reset_pkg::reg_req_t REG_REQ,
  output logic [vol_reset_pkg::DATA_W-1:0] REG_RDATA,
  input wire logic RESET_PIN_N,
  input wire logic INT_RST_REQ,
  input wire logic RAMP_TICK,
  input wire logic ZERO_CROSS,
  output logic [vol_reset_pkg::VOL_W-1:0] EFF_ATTEN,
  output logic CORE_RST_N,
  output logic RAMP_BUSY
);
  import vol_reset_pkg::*;

  softzero_t softzero_q;
  logic [VOL_W-1:0] vol_q;
  logic ramp_up_after_reset_sel;
  logic ramp_down_before_reset_sel;
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_s3_q;
  logic pin_lvl_q;
  logic rst_req;
  vstate_t st_q;
  vstate_t st_d;
  logic load;
  logic [VOL_W-1:0] target;
  logic [VOL_W-1:0] eff_q;
  logic core_rst_n_q;
  logic busy_q;
  logic [DATA_W-1:0] rdata_q;

  // Register writes; only a power-on reset clears them so modes survive soft resets.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      softzero_q <= SOFTZERO_RST;
      vol_q <= VOL_RST;
      ramp_up_after_reset_sel <= 1'b0;
      ramp_down_before_reset_sel <= 1'b0;
    end else if (REG_REQ.wr) begin
      case (REG_REQ.addr)
        ADDR_VOL_MIX: softzero_q <= softzero_t'(REG_REQ.wdata[SOFTZERO_MSB:SOFTZERO_LSB]);
        ADDR_VOL_A: vol_q <= REG_REQ.wdata[VOL_W-1:0];
        ADDR_MODE3: begin
          ramp_up_after_reset_sel <= REG_REQ.wdata[RAMP_UP_BIT]; // RQ4
          ramp_down_before_reset_sel <= REG_REQ.wdata[RAMP_DN_BIT]; // RQ4
        end
        default: begin
        end
      endcase
    end
  end

  // Registered read data; the ID register ignores writes and unmapped reads return zero.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_q <= RDATA_NONE;
    end else begin
      rdata_q <= RDATA_NONE;
      case (REG_REQ.addr)
        ADDR_VOL_MIX: rdata_q[SOFTZERO_MSB:SOFTZERO_LSB] <= softzero_q;
        ADDR_VOL_A: rdata_q[VOL_W-1:0] <= vol_q;
        ADDR_MODE3: begin
          rdata_q[RAMP_UP_BIT] <= ramp_up_after_reset_sel;
          rdata_q[RAMP_DN_BIT] <= ramp_down_before_reset_sel;
        end
        ADDR_ID: begin
          rdata_q[ID_PART_MSB:ID_PART_LSB] <= PART_CODE; // RQ7
          rdata_q[ID_REV_MSB:0] <= REVISION; // RQ7
        end
        default: begin
        end
      endcase
    end
  end

  // Pin reset synchroniser; the filtered level moves only when stages two and three agree.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
      pin_lvl_q <= 1'b0;
    end else begin
      pin_s1_q <= RESET_PIN_N;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      if (pin_s2_q == pin_s3_q) begin
        pin_lvl_q <= pin_s3_q;
      end
    end
  end

  assign rst_req = !pin_lvl_q || INT_RST_REQ; // RQ3

  always_comb begin
    st_d = st_q;
    case (st_q)
      S_HELD: begin
        if (!rst_req) begin
          st_d = S_RAMP_UP; // RQ3
        end
      end
      S_RUN, S_RAMP_UP: begin
        if (rst_req) begin
          st_d = ramp_down_before_reset_sel ? S_RAMP_DOWN : S_HELD; // RQ5 RQ6
        end else if (st_q == S_RAMP_UP && eff_q == vol_q) begin
          st_d = S_RUN;
        end
      end
      S_RAMP_DOWN: begin
        if (eff_q == ATTEN_MAX) begin
          st_d = S_HELD; // RQ6
        end
      end
      default: st_d = S_HELD;
    endcase
  end

  always_comb begin
    load = 1'b0;
    target = vol_q;
    case (st_q)
      S_HELD: begin
        load = 1'b1; // RQ10
        target = ATTEN_MAX; // RQ10
      end
      S_RAMP_UP: load = !ramp_up_after_reset_sel; // RQ1 RQ2
      S_RAMP_DOWN: target = ATTEN_MAX; // RQ6
      default: target = vol_q;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q <= S_HELD;
      core_rst_n_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      core_rst_n_q <= (st_d != S_HELD);
      busy_q <= (st_d == S_RAMP_UP) || (st_d == S_RAMP_DOWN);
    end
  end

  atten_stepper #(
    .W(VOL_W)
  ) u_stepper (
    .clk(CLK),
    .arst_n(ARST_N),
    .load(load),
    .target(target),
    .reset_val(ATTEN_MAX),
    .mode(softzero_q),
    .tick(RAMP_TICK),
    .zero(ZERO_CROSS),
    .cur_q(eff_q)
  );

  assign EFF_ATTEN = eff_q;
  assign CORE_RST_N = core_rst_n_q;
  assign RAMP_BUSY = busy_q;
  assign REG_RDATA = rdata_q;

  held_max_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RQ10
    (st_q == S_HELD) |=> (eff_q == ATTEN_MAX))
    else $error("Volume not at max attenuation while reset held.");

  jump_up_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RQ1
    (st_q == S_HELD && !rst_req && !ramp_up_after_reset_sel)
    |=> ##1 (eff_q == $past(vol_q)))
    else $error("Volume did not jump to setting on release.");

  ramp_step_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RQ2
    (st_q == S_RAMP_UP && ramp_up_after_reset_sel && softzero_q == SZ_SOFT
     && eff_q > vol_q)
    |=> (eff_q == $past(eff_q) - 7'h01 || eff_q == $past(eff_q)))
    else $error("Ramp up moved by more than one step.");

  ramp_hold_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RQ8
    (st_q != S_HELD && softzero_q == SZ_SOFT && !RAMP_TICK && !load)
    |=> $stable(eff_q))
    else $error("Soft ramp stepped without a tick.");

  zero_wait_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RQ8
    (st_q == S_RAMP_DOWN && softzero_q == SZ_ZERO && !ZERO_CROSS) |=> $stable(eff_q))
    else $error("Zero cross mode changed volume without a crossing.");

  down_jump_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RQ5
    (st_q == S_RUN && rst_req && !ramp_down_before_reset_sel)
    |=> (st_q == S_HELD && !CORE_RST_N) ##1 (eff_q == ATTEN_MAX))
    else $error("Reset without ramp did not jump to max attenuation.");

  down_ramp_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RQ6
    (st_q == S_RUN && rst_req && ramp_down_before_reset_sel)
    |=> (st_q == S_RAMP_DOWN && CORE_RST_N))
    else $error("Reset took effect before ramp down.");

  pin_release_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RQ3
    (st_q == S_HELD && pin_lvl_q && !$past(pin_lvl_q) && !INT_RST_REQ)
    |-> ##1 (st_q == S_RAMP_UP && CORE_RST_N))
    else $error("Pin reset release did not start the ramp-up phase.");

  id_read_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RQ7
    (REG_REQ.addr == ADDR_ID) |=> (REG_RDATA == {PART_CODE, REVISION}))
    else $error("Part_and_revision_id read returned a wrong value.");

  ramp_up_done_c: cover property (@(posedge CLK) disable iff (!ARST_N)
    st_q == S_RAMP_UP && ramp_up_after_reset_sel ##1 st_q == S_RUN);

  ramp_down_done_c: cover property (@(posedge CLK) disable iff (!ARST_N)
    st_q == S_RAMP_DOWN ##1 st_q == S_HELD);

  id_read_c: cover property (@(posedge CLK) disable iff (!ARST_N)
    REG_REQ.addr == ADDR_ID && !REG_REQ.wr);

endmodule

//--- test/testbench.sv
// Self-checking bench for the reset volume ramp block.
// Assumes the design package and the top module are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; $display("CHECK FAILED at %0t: got %h expected %h", $time, a, b); end end
module testbench;
  import vol_reset_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic reset_pin_n = 1'b1;
  logic int_rst_req = 1'b0;
  logic ramp_tick = 1'b0;
  logic zero_cross = 1'b0;
  reg_req_t req = '0;
  logic [DATA_W-1:0] rdata;
  logic [VOL_W-1:0] eff;
  logic core_rst_n;
  logic busy;
  int n_errors = 0;
  int checks = 0;
  logic [VOL_W-1:0] exp_tab [4][3];
  localparam logic [3:0] PART_CODE_E = 4'h5;
  localparam logic [3:0] REVISION_E = 4'h1;

  reset_volume_ramp #(.PART_CODE(PART_CODE_E), .REVISION(REVISION_E)) uut (.CLK(clk),
    .ARST_N(arst_n), .REG_REQ(req), .REG_RDATA(rdata),
    .RESET_PIN_N(reset_pin_n), .INT_RST_REQ(int_rst_req), .RAMP_TICK(ramp_tick),
    .ZERO_CROSS(zero_cross), .EFF_ATTEN(eff), .CORE_RST_N(core_rst_n), .RAMP_BUSY(busy));

  always #25 clk = ~clk;

  task automatic end_of_test();
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic step();
    @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    step();
    req.wr = 1'b0;
    step();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    req.addr = a;
    step();
    `CHK(rdata, e)
  endtask

  // Waits a bounded time for the reset output and, optionally, the busy flag.
  task automatic wait_for(input logic want_rst, input logic want_busy, input logic use_busy);
    int i;
    for (i = 0; i < 40; i++) begin
      if (core_rst_n === want_rst && (!use_busy || busy === want_busy)) break;
      step();
    end
    `CHK(i < 40, 1'b1)
  endtask

  task automatic pulse(input logic t, input logic z);
    ramp_tick = t;
    zero_cross = z;
    step();
    ramp_tick = 1'b0;
    zero_cross = 1'b0;
    step();
  endtask

  task automatic int_reset();
    int_rst_req = 1'b1;
    step();
    step();
    `CHK(core_rst_n, 1'b0)
    `CHK(eff, ATTEN_MAX)
    int_rst_req = 1'b0;
  endtask

  task automatic t_power_up();
    wait_for(1'b1, 1'b0, 1'b1);
    `CHK(eff, 7'h00)
    rd(8'h02, 8'h40);
    rd(8'h03, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h07, {PART_CODE_E, REVISION_E});
    wr(8'h07, 8'hff);
    rd(8'h07, {PART_CODE_E, REVISION_E});
    rd(8'h10, 8'h00);
    wr(8'h06, 8'hff);
    rd(8'h06, 8'h0c);
    wr(8'h06, 8'h00);
  endtask

  task automatic t_jump();
    wr(8'h03, 8'h14);
    int_reset();
    wait_for(1'b1, 1'b0, 1'b1);
    `CHK(eff, 7'h14)
  endtask

  // Pin reset with soft ramp-up: one 1 dB step per tick only.
  task automatic t_pin_ramp_up();
    wr(8'h03, 8'h7c);
    wr(8'h06, 8'h08);
    reset_pin_n = 1'b0;
    wait_for(1'b0, 1'b0, 1'b1);
    step();
    `CHK(eff, ATTEN_MAX)
    reset_pin_n = 1'b1;
    wait_for(1'b1, 1'b1, 1'b1);
    repeat (3) step();
    `CHK(eff, ATTEN_MAX)
    for (int k = 1; k <= 3; k++) begin
      pulse(1'b1, 1'b0);
      `CHK(eff, 7'(8'h7f - k))
    end
    wait_for(1'b1, 1'b0, 1'b1);
  endtask

  // A one-cycle request still completes the ramp-down before the core reset.
  task automatic t_ramp_down();
    wr(8'h06, 8'h04);
    int_rst_req = 1'b1;
    step();
    int_rst_req = 1'b0;
    wait_for(1'b1, 1'b1, 1'b1);
    for (int k = 1; k <= 3; k++) begin
      if (k < 3) `CHK(core_rst_n, 1'b1)
      pulse(1'b1, 1'b0);
      `CHK(eff, 7'(8'h7c + k))
    end
    wait_for(1'b0, 1'b0, 1'b1);
    wait_for(1'b1, 1'b0, 1'b1);
    `CHK(eff, 7'h7c)
  endtask

  task automatic t_modes();
    wr(8'h03, 8'h7d);
    wr(8'h06, 8'h08);
    for (int m = 0; m < 4; m++) begin
      wr(8'h02, {1'b0, 2'(m), 5'h00});
      rd(8'h02, {1'b0, 2'(m), 5'h00});
      int_reset();
      wait_for(1'b1, 1'b0, 1'b0);
      pulse(1'b1, 1'b0);
      `CHK(eff, exp_tab[m][0])
      pulse(1'b0, 1'b1);
      `CHK(eff, exp_tab[m][1])
      pulse(1'b1, 1'b1);
      `CHK(eff, exp_tab[m][2])
      pulse(1'b1, 1'b1);
      wait_for(1'b1, 1'b0, 1'b1);
      `CHK(eff, 7'h7d)
    end
  endtask

  initial begin
    exp_tab = '{'{7'h7d, 7'h7d, 7'h7d}, '{7'h7f, 7'h7d, 7'h7d},
                '{7'h7e, 7'h7e, 7'h7d}, '{7'h7f, 7'h7f, 7'h7e}};
    repeat (2) step();
    `CHK(eff, ATTEN_MAX)
    `CHK(core_rst_n, 1'b0)
    `CHK(busy, 1'b0)
    `CHK(rdata, 8'h00)
    arst_n = 1'b1;
    t_power_up();
    t_jump();
    t_pin_ramp_up();
    t_ramp_down();
    t_modes();
    end_of_test();
  end

  // The whole sequence needs well under a thousand cycles.
  initial begin
    #(3000 * 50);
    n_errors++;
    end_of_test();
  end
endmodule
